/* File: core/mise_exec.v */
// Execution unit for a subset of 8-bit controller instructions
`timescale 1ns/1ps
`include "mise_defs.vh"
module mise_exec (
   // Clock and reset
   input  wire        i_clk,
   input  wire        i_rst_n,
   // Instruction fetch
   input  wire        i_instr_valid,
   input  wire [15:0] i_instr,
   input  wire        i_next_two_word,
   input  wire [20:0] i_pc,
   input  wire        i_ext_set_en,
   // Data memory
   input  wire [7:0]  i_file_rdata,
   input  wire [11:0] i_indirect_pointer_two,
   input  wire [7:0]  i_table_latch,
   output reg  [11:0] o_file_addr,
   output reg  [7:0]  o_file_wdata,
   output reg         o_file_we,
   // Program flow and return stack
   output reg         o_pc_load,
   output reg  [20:0] o_pc_target,
   output reg         o_stack_push,
   output reg  [20:0] o_top_of_stack,
   output wire        o_busy,
   output reg         o_soft_reset,
   // Architectural state
   output reg  [7:0]  o_accum,
   output reg  [3:0]  o_bank_select_register,
   output reg  [20:0] o_table_pointer,
   output wire [63:0] o_holding_regs
);
   localparam [1:0] ST_EXEC = 2'h0;
   localparam [1:0] ST_NOP  = 2'h1;
   localparam [1:0] ST_TBLW = 2'h2;

   reg  [1:0]  state_ff;
   reg  [1:0]  nops_ff;
   reg  [1:0]  tw_mode_ff;
   reg  [7:0]  hold_ff [0:7];
   reg  [1:0]  nxt_state;
   reg  [1:0]  nxt_nops;
   reg  [7:0]  dec_val;
   reg         skip;
   reg  [7:0]  nxt_accum;
   reg  [20:0] nxt_ptr;

   // Effective data address for byte-oriented operands
   function [11:0] eff_addr;
      input [7:0]  f;
      input        a;
      input        ext;
      input [3:0]  bank;
      input [11:0] ptr2;
      begin
         if (!a && ext && f <= `MISE_ILO_MAX)
            eff_addr = ptr2 + {4'h0, f}; // RQ4 RQ6
         else if (a)
            eff_addr = {bank, f}; // RQ5
         else if (f < `MISE_ACCESS_HI)
            eff_addr = {4'h0, f}; // RQ5
         else
            eff_addr = {`MISE_SFR_BANK, f}; // RQ5
      end
   endfunction

   wire        in_exec  = i_instr_valid && (state_ff == ST_EXEC);
   wire        is_dsz   = i_instr[15:10] == `MISE_OP_DSZ;
   wire        is_dsnz  = i_instr[15:10] == `MISE_OP_DSNZ;
   wire        is_ldlit = i_instr[15:8] == `MISE_OP_LDLIT;
   wire        is_store = i_instr[15:9] == `MISE_OP_STORE;
   wire        is_relative_subroutine_call = i_instr[15:11] == `MISE_OP_RELATIVE_SUBROUTINE_CALL;
   wire        is_swrst = i_instr == `MISE_OP_SWRST;
   wire        is_table_write_op = i_instr[15:2] == `MISE_OP_TABLE_WRITE_OP;
   wire [20:0] pc_next  = i_pc + 21'h000002;
   wire [20:0] rel_off  = {{9{i_instr[10]}}, i_instr[10:0], 1'b0}; // RQ9
   wire [20:0] ptr_inc  = o_table_pointer + 21'h000001;
   wire [20:0] ptr_dec  = o_table_pointer - 21'h000001;

   assign o_busy = state_ff != ST_EXEC;

   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_hold
         assign o_holding_regs[g*8 +: 8] = hold_ff[g]; // RQ16
      end
   endgenerate

   always @* begin
      dec_val   = i_file_rdata - 8'h01; // RQ1
      skip      = (is_dsz && dec_val == 8'h00) || (is_dsnz && dec_val != 8'h00); // RQ2
      nxt_state = state_ff;
      nxt_nops  = nops_ff;
      case (state_ff)
         ST_EXEC: begin
            if (in_exec && (is_dsz || is_dsnz) && skip) begin
               nxt_state = ST_NOP;
               nxt_nops  = i_next_two_word ? 2'h1 : 2'h0; // RQ3
            end else if (in_exec && is_relative_subroutine_call) begin
               nxt_state = ST_NOP; // RQ10
               nxt_nops  = 2'h0;
            end else if (in_exec && is_table_write_op) begin
               nxt_state = ST_TBLW; // RQ15
            end
         end
         ST_NOP: begin
            if (nops_ff == 2'h0)
               nxt_state = ST_EXEC;
            else
               nxt_nops = nops_ff - 2'h1;
         end
         ST_TBLW: nxt_state = ST_EXEC;
         default: nxt_state = ST_EXEC;
      endcase
   end

   // Qualified instruction strobes and the shared operand address
   wire        take_dec   = in_exec && (is_dsz || is_dsnz);
   wire        take_store = in_exec && is_store;
   wire        take_relative_subroutine_call = in_exec && is_relative_subroutine_call;
   wire        take_table_write_op = in_exec && is_table_write_op;
   wire        tw_step    = state_ff == ST_TBLW;
   wire        clr        = !i_rst_n || o_soft_reset; // RQ11
   wire [11:0] op_addr    = eff_addr(i_instr[7:0], i_instr[8], i_ext_set_en,
                                     o_bank_select_register, i_indirect_pointer_two);
   integer     k;

   // Sequencer state; a soft reset pulse clears it like an external reset
   always @(posedge i_clk) begin
      if (clr) begin
         state_ff <= ST_EXEC; // RQ11
         nops_ff  <= 2'h0;
      end else begin
         state_ff <= nxt_state;
         nops_ff  <= nxt_nops;
      end
   end

   // Accumulator
   always @* begin
      nxt_accum = o_accum;
      if (take_dec && !i_instr[9])
         nxt_accum = dec_val; // RQ1
      else if (in_exec && is_ldlit)
         nxt_accum = i_instr[7:0]; // RQ7
   end

   always @(posedge i_clk) begin
      if (clr)
         o_accum <= `MISE_RST_ACC;
      else
         o_accum <= nxt_accum;
   end

   // No instruction of this subset writes the bank select register
   always @(posedge i_clk) begin
      if (clr)
         o_bank_select_register <= `MISE_RST_BANK;
      else
         o_bank_select_register <= o_bank_select_register;
   end

   // Data memory write port, one strobe per store or per decrement with d set to 1
   always @(posedge i_clk) begin
      if (clr) begin
         o_file_addr  <= 12'h000;
         o_file_wdata <= 8'h00;
         o_file_we    <= 1'b0;
      end else begin
         o_file_we <= (take_dec && i_instr[9]) || take_store;
         if (take_dec && i_instr[9]) begin
            o_file_addr  <= op_addr; // RQ4 RQ5 RQ6
            o_file_wdata <= dec_val; // RQ1
         end else if (take_store) begin
            o_file_addr  <= op_addr; // RQ4 RQ5 RQ6
            o_file_wdata <= o_accum; // RQ8
         end
      end
   end

   // Relative call: push the return address and load the target together
   always @(posedge i_clk) begin
      if (clr) begin
         o_pc_load      <= 1'b0;
         o_stack_push   <= 1'b0;
         o_pc_target    <= 21'h000000;
         o_top_of_stack <= 21'h000000;
      end else begin
         o_pc_load    <= take_relative_subroutine_call;
         o_stack_push <= take_relative_subroutine_call; // RQ10
         if (take_relative_subroutine_call) begin
            o_top_of_stack <= pc_next; // RQ10
            o_pc_target    <= pc_next + rel_off; // RQ9
         end
      end
   end

   // Software reset pulse, which clears every register on the next edge
   always @(posedge i_clk) begin
      if (clr)
         o_soft_reset <= 1'b0;
      else
         o_soft_reset <= in_exec && is_swrst; // RQ11
   end

   // Table pointer: pre-increment at take, post-update with the holding write
   always @* begin
      nxt_ptr = o_table_pointer;
      if (take_table_write_op && i_instr[1:0] == `MISE_TW_PREINC)
         nxt_ptr = ptr_inc; // RQ14
      else if (tw_step && tw_mode_ff == `MISE_TW_POSTINC)
         nxt_ptr = ptr_inc; // RQ14
      else if (tw_step && tw_mode_ff == `MISE_TW_POSTDEC)
         nxt_ptr = ptr_dec; // RQ14
   end

   always @(posedge i_clk) begin
      if (clr) begin
         o_table_pointer <= `MISE_RST_PTR;
         tw_mode_ff      <= `MISE_TW_NONE;
      end else begin
         o_table_pointer <= nxt_ptr; // RQ13
         if (take_table_write_op)
            tw_mode_ff <= i_instr[1:0];
      end
   end

   // Holding registers stage program-memory data for a later flash write
   always @(posedge i_clk) begin
      if (clr) begin
         for (k = 0; k < 8; k = k + 1)
            hold_ff[k] <= `MISE_RST_HOLD;
      end else if (tw_step) begin
         hold_ff[o_table_pointer[2:0]] <= i_table_latch; // RQ12 RQ13 RQ15
      end
   end
endmodule // mise_exec

/* File: pkg/mise_defs.vh */
// Constants for the instruction subset execution unit
// Functional notes
// RQ1 - Decrement-and-skip subtracts one from the file register and writes to the accumulator when d is 0, else back to the file register.
// RQ2 - The zero variant skips the next instruction on a zero result, the non-zero variant on a non-zero result, and no flag changes.
// RQ3 - A skip discards the fetched next instruction as a no-operation, costing two cycles, or three when that instruction is two words.
// RQ4 - With access bit 0 and the extended set on, an operand of 95 or less uses indexed literal offset addressing for decrement-skip and store.
// RQ5 - With the extended set off, access bit 0 selects the access bank and access bit 1 the bank chosen by the bank select register.
// RQ6 - In indexed literal offset mode the effective address is the operand plus indirect pointer two.
// RQ7 - Load literal puts the 8-bit immediate into the accumulator in one word and one cycle.
// RQ8 - Store copies the accumulator into the addressed file register in one cycle without touching any flag.
// RQ9 - Relative call takes a signed 11-bit offset and jumps to the incremented program counter plus twice the offset.
// RQ10 - Relative call pushes the following instruction's address in its first cycle and spends a no-operation second cycle.
// RQ11 - Software reset returns every register and flag to its master clear reset value in one cycle.
// RQ12 - Table write uses the low 3 bits of the table pointer to choose one of 8 holding registers for the table latch byte.
// RQ13 - The table pointer is 21 bits wide with bit 0 choosing the low or high byte of a program word.
// RQ14 - Table write supports no change, post-increment, post-decrement and pre-increment, the last updating before the write.
// RQ15 - Table write takes two cycles, reading the latch and writing the holding register in the second.
// RQ16 - The holding registers stage data for a later program flash programming operation.
`ifndef MISE_DEFS_VH
`define MISE_DEFS_VH
`define MISE_OP_DSZ     6'h0b
`define MISE_OP_DSNZ    6'h13
`define MISE_OP_LDLIT   8'h0e
`define MISE_OP_STORE   7'h37
`define MISE_OP_RELATIVE_SUBROUTINE_CALL   5'h1b
`define MISE_OP_SWRST   16'h00ff
`define MISE_OP_TABLE_WRITE_OP   14'h0003
`define MISE_ILO_MAX    8'h5f
`define MISE_ACCESS_HI  8'h60
`define MISE_SFR_BANK   4'hf
`define MISE_TW_NONE    2'h0
`define MISE_TW_POSTINC 2'h1
`define MISE_TW_POSTDEC 2'h2
`define MISE_TW_PREINC  2'h3
`define MISE_PC_W       21
`define MISE_RST_ACC    8'h00
`define MISE_RST_BANK   4'h0
`define MISE_RST_PTR    21'h000000
`define MISE_RST_HOLD   8'hff
`endif

/* File: tb/mise_exec_sva.sv */
// Port assertions for the execution unit
`timescale 1ns/1ps
module mise_exec_sva (
   input wire logic        i_clk, i_rst_n, i_instr_valid, i_next_two_word,
   input wire logic [15:0] i_instr,
   input wire logic [20:0] i_pc, o_pc_target, o_top_of_stack, o_table_pointer,
   input wire logic [7:0]  i_file_rdata, o_file_wdata, o_accum,
   input wire logic        o_file_we, o_pc_load, o_stack_push, o_busy, o_soft_reset
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   wire        tk   = i_instr_valid && !o_busy;
   wire        call = tk && i_instr[15:11] == 5'h1b;
   wire        dec  = tk && (i_instr[15:10] == 6'h0b || i_instr[15:10] == 6'h13);
   wire        skp  = (i_file_rdata == 8'h1) ^ i_instr[14];
   wire [20:0] rel  = {{9{i_instr[10]}}, i_instr[10:0], 1'b0};
   sequence one_stall; o_busy ##1 !o_busy; endsequence
   ldlit_acc_a: assert property (tk && i_instr[15:8] == 8'h0e |=>
      o_accum == $past(i_instr[7:0])) else $error("literal load");
   store_copy_a: assert property (tk && i_instr[15:9] == 7'h37 |=>
      o_file_we && o_file_wdata == $past(o_accum)) else $error("store");
   dec_write_a: assert property (dec && i_instr[9] |=>
      o_file_we && o_file_wdata == $past(i_file_rdata) - 8'h1) else $error("decrement");
   dec_skip_a: assert property (dec |=> o_busy == $past(skp))
      else $error("skip");
   skip_long_a: assert property (dec && skp && i_next_two_word |=>
      o_busy [*2] ##1 !o_busy) else $error("long skip");
   call_push_a: assert property (call |=>
      o_stack_push && o_top_of_stack == $past(i_pc) + 21'h2) else $error("push");
   call_target_a: assert property (call |=>
      o_pc_load && o_pc_target == $past(i_pc) + 21'h2 + $past(rel)) else $error("target");
   call_stall_a: assert property (call |=> one_stall) else $error("call");
   tbl_stall_a: assert property (tk && i_instr[15:2] == 14'h3 |=> one_stall)
      else $error("table write");
   tbl_postinc_a: assert property (tk && i_instr == 16'h000d |->
      ##2 o_table_pointer == $past(o_table_pointer, 2) + 21'h1) else $error("pointer");
   soft_rst_a: assert property (tk && i_instr == 16'h00ff |=>
      o_soft_reset ##1 (o_accum == 8'h0 && o_table_pointer == 21'h0)) else $error("reset");
endmodule // mise_exec_sva
bind mise_exec mise_exec_sva chk_u (.i_clk, .i_rst_n, .i_instr_valid, .i_next_two_word,
   .i_instr, .i_pc, .o_pc_target, .o_top_of_stack, .o_table_pointer, .i_file_rdata,
   .o_file_wdata, .o_accum, .o_file_we, .o_pc_load, .o_stack_push, .o_busy, .o_soft_reset);

/* File: tb/mise_exec_test.sv */
// Self-checking bench for the execution unit
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((e) !== (s)) begin failures++; \
   $display("MISMATCH %s exp %h got %h", n, e, s); end end
module mise_exec_test;
   logic        i_clk, i_rst_n, i_instr_valid, i_next_two_word, i_ext_set_en;
   logic [15:0] i_instr;
   logic [20:0] i_pc, o_pc_target, o_top_of_stack, o_table_pointer, p, x;
   logic [11:0] i_indirect_pointer_two, o_file_addr;
   logic [7:0]  i_file_rdata, i_table_latch, o_file_wdata, o_accum, k, f;
   logic [3:0]  o_bank_select_register;
   logic [63:0] o_holding_regs, h;
   logic        o_file_we, o_pc_load, o_stack_push, o_busy, o_soft_reset;
   logic [20:0] exp_q[$];
   int          failures, num_checks, cyc;
   mise_exec dut_u (.*);
   mise_mem_model mem_u (.i_clk, .i_rd_addr(i_instr[7:0]), .i_we(o_file_we),
      .i_wr_addr(o_file_addr), .i_wdata(o_file_wdata), .o_rdata(i_file_rdata));
   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end
   task automatic complete_run();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic run(input logic [15:0] w);
      i_pc = {20'($urandom), 1'b0};
      if (w[15:11] == 5'h1b) exp_q.push_back(i_pc + 21'h2 + {{9{w[10]}}, w[10:0], 1'b0});
      i_instr = w;
      i_instr_valid = 1'b1;
      @(negedge i_clk);
      if (o_busy === 1'b1) i_instr_valid = 1'b0;
      while (o_busy === 1'b1) @(negedge i_clk);
   endtask
   always @(negedge i_clk) begin
      if (o_file_we === 1'b1) begin
         x = exp_q.pop_front();
         `CHK("file write", x, {1'b0, o_file_addr, o_file_wdata})
      end
      if (o_pc_load === 1'b1) begin
         x = exp_q.pop_front();
         `CHK("call target", x, o_pc_target)
      end
   end
   always @(negedge i_clk) if (++cyc > 2000) begin failures++; complete_run(); end
   initial begin
      void'($urandom(93592));
      {i_rst_n, i_instr_valid, i_next_two_word, i_ext_set_en} = 4'h0;
      {i_instr, i_pc, i_table_latch} = '0;
      i_indirect_pointer_two = {2'b10, 10'($urandom)};
      repeat (12) @(negedge i_clk);
      i_rst_n = 1'b1;
      for (int j = 0; j < 3; j++) begin
         k = 8'($urandom);
         f = (j == 2) ? {1'b1, 7'($urandom)}
                      : {j[0], 1'b0, 6'($urandom)} | (j[0] ? 8'h60 : 8'h0);
         run({8'h0e, k});
         exp_q.push_back({1'b0, j == 1 ? 4'hf : 4'h0, f, k});
         run({7'h37, j == 2, f});
      end
      for (int j = 0; j < 4; j++) begin
         f = (j[1] ^ j[0]) ? 8'h5b : {3'h2, 5'($urandom)};
         k = (f ^ 8'h5a) - 8'h1;
         i_ext_set_en = j[1];
         i_next_two_word = j[0];
         if (j[1]) exp_q.push_back({1'b0, i_indirect_pointer_two + {4'h0, f}, k});
         run({j[0] ? 6'h13 : 6'h0b, j[1], 1'b0, f});
         if (!j[1]) exp_q.push_back({5'h0, 8'h20, k});
         if (!j[1]) run(16'h6e20);
      end
      for (int j = 0; j < 3; j++)
         run({5'h1b, j == 0 ? 11'h400 : j == 1 ? 11'h3ff : 11'($urandom)});
      p = '0;
      h = {8{8'hff}};
      for (int m = 0; m < 8; m++) begin
         i_table_latch = 8'($urandom);
         if (m % 4 == 3) p++;
         h[p[2:0] * 8 +: 8] = i_table_latch;
         run({14'h3, 2'(m)});
         if (m % 4 == 1) p++;
         if (m % 4 == 2) p--;
         `CHK("holding", h, o_holding_regs)
         `CHK("pointer", p, o_table_pointer)
      end
      run(16'h00ff);
      i_instr_valid = 1'b0;
      repeat (2) @(negedge i_clk);
      `CHK("reset", 33'h0, {o_bank_select_register, o_accum, o_table_pointer})
      `CHK("reset holding", {8{8'hff}}, o_holding_regs)
      complete_run();
   end
endmodule // mise_exec_test

/* File: tb/mise_mem_model.sv */
// Data memory model: operand reads and file writes
`timescale 1ns/1ps
module mise_mem_model (
   input  wire logic        i_clk,
   input  wire logic [7:0]  i_rd_addr,
   input  wire logic        i_we,
   input  wire logic [11:0] i_wr_addr,
   input  wire logic [7:0]  i_wdata,
   output wire logic [7:0]  o_rdata
);
   logic [7:0] mem [0:4095];
   initial for (int k = 0; k < 4096; k++) mem[k] = k[7:0] ^ 8'h5a;
   assign o_rdata = mem[{4'h0, i_rd_addr}];
   always @(posedge i_clk) if (i_we) mem[i_wr_addr] <= i_wdata;
endmodule // mise_mem_model
